/* File: chc_device.sv */
`timescale 1ns/1ns
`default_nettype none
module chc_device #(
    parameter int WAKE_CYCLES = chc_pkg::WAKE_CYCLES
) (
    input wire logic mclk,
    input wire logic reset,
    chc_if.dev bus,
    input wire logic crc_mismatch,
    input wire logic rx_done,
    input wire logic tx_done,
    input wire logic obj_irq,
    input wire logic bus_activity,
    input wire logic port_bit6_in,
    output logic core_clk_en,
    output logic host_clk_en,
    output logic clock_out,
    output logic osc_run,
    output logic objects_blocked,
    output logic irq_main_n,
    output logic irq_alt_n,
    output logic [1:0] power_mode
);
    logic [7:0] hic_q, hic_d;
    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] stat_q, stat_d;
    logic [7:0] irq_id_q, irq_id_d;
    logic [15:0] frb_q, frb_d;
    logic [15:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;
    logic [7:0] mem_q [0:15];
    logic [1:0] div_q, div_d;
    logic [24:0] wake_cnt_q, wake_cnt_d;
    logic wake_pend_q, wake_pend_d;
    logic core_en_q, core_en_d;
    logic host_en_q, host_en_d;
    logic clk_out_q, clk_out_d;
    logic irq_main_q, irq_main_d;
    logic irq_alt_q, irq_alt_d;
    logic osc_q, osc_d, blk_q, blk_d;
    logic low_power;

    // Mode decode, shared by access gating and clock stopping
    function automatic logic is_low_power(input logic [7:0] h);
        return h[chc_pkg::HIC_PD] | h[chc_pkg::HIC_SLEEP];
    endfunction : is_low_power

    assign low_power = is_low_power(hic_q);

    // Register, interrupt and clock next-state logic
    always_comb begin
        hic_d = hic_q;
        hic_d[chc_pkg::HIC_RST] = 1'b0;
        ctrl_d = ctrl_q;
        stat_d = stat_q;
        irq_id_d = irq_id_q;
        frb_d = frb_q;
        rdata_d = rdata_q;
        rvalid_d = 1'b0;
        div_d = div_q + 2'h1;
        wake_cnt_d = wake_cnt_q;
        wake_pend_d = wake_pend_q;
        // Divider as enables: no derived clock, no glitch on bit change
        core_en_d = ~hic_q[chc_pkg::HIC_CORE_HALVE] | div_q[0];
        host_en_d = core_en_d & (~hic_q[chc_pkg::HIC_HOST_HALVE]
            | (hic_q[chc_pkg::HIC_CORE_HALVE] ? div_q[1] : div_q[0]));
        clk_out_d = ~low_power & hic_q[chc_pkg::HIC_CLKOUT]
            & ~clk_out_q;
        if (low_power) begin
            core_en_d = 1'b0;
            host_en_d = 1'b0;
        end
        // Bus side: only the interface register and the read buffer while in low power
        if (bus.wr) begin
            if (bus.addr == chc_pkg::OFF_HIC) begin
                hic_d = bus.wdata[7:0];
                hic_d[chc_pkg::HIC_RST] = 1'b0;
                if (hic_q[chc_pkg::HIC_SLEEP]
                        & ~bus.wdata[chc_pkg::HIC_SLEEP]) begin
                    wake_pend_d = 1'b0;
                end
            end else if (!low_power) begin
                if (bus.addr == chc_pkg::OFF_CTRL) begin
                    ctrl_d = bus.wdata[7:0];
                end else if (bus.addr == chc_pkg::OFF_STATUS) begin
                    stat_d[4:0] = bus.wdata[4:0];
                end else if (bus.addr[7:4] == 4'h1) begin
                    // Object memory, blocked in low power
                end
            end
        end
        if (bus.rd) begin
            rvalid_d = 1'b1;
            rdata_d = 16'h0000;
            if (bus.addr == chc_pkg::OFF_HIC) begin
                rdata_d = {8'h00, hic_q};
            end else if (bus.addr == chc_pkg::OFF_FRB_LO) begin
                rdata_d = frb_q;
            end else if (bus.addr == chc_pkg::OFF_FRB_HI) begin
                rdata_d = {8'h00, frb_q[15:8]};
            end else if (!low_power) begin
                // Slow read: data unreliable, buffer captures it
                if (bus.addr == chc_pkg::OFF_STATUS) begin
                    rdata_d = {8'h00, stat_q};
                    stat_d[chc_pkg::ST_WAKE] = 1'b0;
                    if (irq_id_q == chc_pkg::IRQ_STATUS) begin
                        irq_id_d = chc_pkg::IRQ_NONE;
                    end
                end else if (bus.addr == chc_pkg::OFF_CTRL) begin
                    rdata_d = {8'h00, ctrl_q};
                end else if (bus.addr == chc_pkg::OFF_IRQ_ID) begin
                    rdata_d = {8'h00, irq_id_q};
                end else if (bus.addr[7:4] == 4'h1) begin
                    rdata_d = {mem_q[bus.addr[3:0] + 4'h1],
                        mem_q[bus.addr[3:0]]};
                end
                // Wide read fills both bytes, narrow only the low
                frb_d = bus.wide ? rdata_d
                    : {frb_q[15:8], rdata_d[7:0]};
            end
        end
        // Wake-up: held low asleep, delayed set after bus activity
        if (hic_q[chc_pkg::HIC_SLEEP]) begin
            stat_d[chc_pkg::ST_WAKE] = 1'b0;
            if (bus_activity & ~wake_pend_d) begin
                wake_pend_d = 1'b1;
                wake_cnt_d = 25'(WAKE_CYCLES);
            end else if (wake_pend_q & (wake_cnt_q != 25'h0000000)) begin
                wake_cnt_d = wake_cnt_q - 25'h0000001;
            end else if (wake_pend_q) begin
                hic_d[chc_pkg::HIC_SLEEP] = 1'b0;
                wake_pend_d = 1'b0;
            end
        end
        if (~hic_d[chc_pkg::HIC_SLEEP] & hic_q[chc_pkg::HIC_SLEEP]) begin
            stat_d[chc_pkg::ST_WAKE] = 1'b1;
        end
        if (~hic_d[chc_pkg::HIC_PD] & hic_q[chc_pkg::HIC_PD]) begin
            stat_d[chc_pkg::ST_WAKE] = 1'b1;
        end
        // Events after clears so set wins
        if (crc_mismatch) begin
            stat_d[2:0] = chc_pkg::LEC_CRC;
        end
        if (rx_done) begin
            stat_d[chc_pkg::ST_RX_SUCCESS_FLAG] = 1'b1;
        end
        if (tx_done) begin
            stat_d[chc_pkg::ST_TX_SUCCESS_FLAG] = 1'b1;
        end
        if ((rx_done | tx_done) & ctrl_q[chc_pkg::CT_SIE]) begin
            irq_id_d = chc_pkg::IRQ_STATUS;
        end
        // Line asserts while any cause pends and global enable set
        irq_main_d = ~(ctrl_q[chc_pkg::CT_IE]
            & ((irq_id_q != chc_pkg::IRQ_NONE) | obj_irq));
        irq_alt_d = port_bit6_in;
        if (hic_q[chc_pkg::HIC_REMAP]) begin
            irq_alt_d = irq_main_d;
            irq_main_d = 1'b1;
        end
        // Mode pins taken from the next value keep step with hic_q
        osc_d = ~is_low_power(hic_d);
        blk_d = is_low_power(hic_d);
    end

    // Register stage; reset forces the in-reset pattern
    always_ff @(posedge mclk) begin
        if (reset) begin
            hic_q <= chc_pkg::HIC_IN_RESET;
            ctrl_q <= 8'h01;
            stat_q <= 8'h00;
            irq_id_q <= chc_pkg::IRQ_NONE;
            rdata_q <= 16'h0000;
            rvalid_q <= 1'b0;
            div_q <= 2'h0;
            wake_cnt_q <= 25'h0000000;
            wake_pend_q <= 1'b0;
            core_en_q <= 1'b0;
            host_en_q <= 1'b0;
            clk_out_q <= 1'b0;
            irq_main_q <= 1'b1;
            irq_alt_q <= 1'b1;
            osc_q <= 1'b1;
            blk_q <= 1'b0;
        end else begin
            hic_q <= hic_d;
            ctrl_q <= ctrl_d;
            stat_q <= stat_d;
            irq_id_q <= irq_id_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
            div_q <= div_d;
            wake_cnt_q <= wake_cnt_d;
            wake_pend_q <= wake_pend_d;
            core_en_q <= core_en_d;
            host_en_q <= host_en_d;
            clk_out_q <= clk_out_d;
            irq_main_q <= irq_main_d;
            irq_alt_q <= irq_alt_d;
            osc_q <= osc_d;
            blk_q <= blk_d;
        end
    end

    // Fast buffer holds value across reset (unchanged)
    always_ff @(posedge mclk) begin
        frb_q <= frb_d;
    end

    // Object memory, unchanged by reset
    always_ff @(posedge mclk) begin
        if (!reset && bus.wr && !low_power && bus.addr[7:4] == 4'h1) begin
            mem_q[bus.addr[3:0]] <= bus.wdata[7:0];
        end
    end

    assign bus.rdata = rdata_q;
    assign bus.rvalid = rvalid_q;
    assign core_clk_en = core_en_q;
    assign host_clk_en = host_en_q;
    assign clock_out = clk_out_q;
    assign osc_run = osc_q;
    assign objects_blocked = blk_q;
    assign irq_main_n = irq_main_q;
    assign irq_alt_n = irq_alt_q;
    assign power_mode = {hic_q[chc_pkg::HIC_PD], hic_q[chc_pkg::HIC_SLEEP]};
endmodule : chc_device
`default_nettype wire

/* File: chc_pkg.sv */
package chc_pkg;
    // Register offsets on the device bus
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h01;
    localparam logic [7:0] OFF_HIC = 8'h02;
    localparam logic [7:0] OFF_FRB_LO = 8'h04;
    localparam logic [7:0] OFF_FRB_HI = 8'h05;
    localparam logic [7:0] OFF_IRQ_ID = 8'h5F;
    // Host command registers of our own
    localparam logic [3:0] CMD_ADDR = 4'h0;
    localparam logic [3:0] CMD_WDATA = 4'h1;
    localparam logic [3:0] CMD_GO = 4'h2;
    localparam logic [3:0] CMD_RDATA = 4'h3;
    localparam logic [3:0] CMD_STAT = 4'h4;
    // Interface register fields
    localparam int HIC_RST = 7;
    localparam int HIC_CORE_HALVE = 6;
    localparam int HIC_HOST_HALVE = 5;
    localparam int HIC_PD = 4;
    localparam int HIC_SLEEP = 3;
    localparam int HIC_REMAP = 2;
    localparam int HIC_RSVD = 1;
    localparam int HIC_CLKOUT = 0;
    localparam logic [7:0] HIC_IN_RESET = 8'hE1;
    localparam logic [7:0] HIC_RESET = 8'h61;
    // Status and control fields
    localparam int ST_WAKE = 5;
    localparam int ST_RX_SUCCESS_FLAG = 4;
    localparam int ST_TX_SUCCESS_FLAG = 3;
    localparam int CT_IE = 1;
    localparam int CT_SIE = 2;
    localparam logic [2:0] LEC_CRC = 3'h6;
    localparam logic [7:0] IRQ_STATUS = 8'h01;
    localparam logic [7:0] IRQ_NONE = 8'h00;
    // Sleep wake-up delay
    localparam int WAKE_MS = 10;
    localparam int CLK_HZ = 25000000;
    localparam int WAKE_CYCLES = (CLK_HZ / 1000) * WAKE_MS;
endpackage : chc_pkg

/* File: chc_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface chc_if;
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
    logic wide;
    logic [15:0] rdata;
    logic rvalid;
    modport dev (input addr, wdata, wr, rd, wide, output rdata, rvalid);
    modport host (output addr, wdata, wr, rd, wide, input rdata, rvalid);
endinterface : chc_if
`default_nettype wire

/* File: chc_host.sv */
`timescale 1ns/1ns
`default_nettype none
// Host end: software orders one device access at a time via
// its own command registers; it refuses orders while the device
// reset flag stands and masks the reserved bit on interface writes.
module chc_host (
    input wire logic mclk,
    input wire logic reset,
    chc_if.host bus,
    input wire logic [3:0] sw_addr,
    input wire logic [15:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [15:0] sw_rdata
);
    typedef enum logic [1:0] {CHC_PROBE, CHC_IDLE, CHC_WAIT} chc_state_t;
    chc_state_t st_q, st_d;
    logic [7:0] addr_q, addr_d;
    logic [15:0] wdata_q, wdata_d;
    logic [15:0] res_q, res_d;
    logic [15:0] srd_q, srd_d;
    logic wr_q, wr_d, rd_q, rd_d, wide_q, wide_d;
    logic ready_q, ready_d;

    // Sequencer and software port
    always_comb begin
        st_d = st_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        res_d = res_q;
        ready_d = ready_q;
        wr_d = 1'b0;
        rd_d = 1'b0;
        wide_d = wide_q;
        srd_d = 16'h0000;
        if (sw_wr & (sw_addr == chc_pkg::CMD_ADDR)) begin
            addr_d = sw_wdata[7:0];
            wide_d = sw_wdata[8];
        end
        if (sw_wr & (sw_addr == chc_pkg::CMD_WDATA)) begin
            wdata_d = sw_wdata;
        end
        unique case (st_q)
            CHC_PROBE: begin
                // Poll reset flag before any other access
                if (bus.rvalid & ~bus.rdata[chc_pkg::HIC_RST]) begin
                    st_d = CHC_IDLE;
                    ready_d = 1'b1;
                end else if (~rd_q & ~bus.rvalid) begin
                    rd_d = 1'b1;
                    addr_d = chc_pkg::OFF_HIC;
                end
            end
            CHC_IDLE: begin
                if (sw_wr & (sw_addr == chc_pkg::CMD_GO)) begin
                    ready_d = 1'b0;
                    if (sw_wdata[0]) begin
                        rd_d = 1'b1;
                        st_d = CHC_WAIT;
                    end else begin
                        wr_d = 1'b1;
                        if (addr_q == chc_pkg::OFF_HIC) begin
                            wdata_d[chc_pkg::HIC_RSVD] = 1'b0;
                        end
                        ready_d = 1'b1;
                    end
                end
            end
            CHC_WAIT: begin
                if (bus.rvalid) begin
                    res_d = bus.rdata;
                    ready_d = 1'b1;
                    st_d = CHC_IDLE;
                end
            end
        endcase
        if (sw_rd) begin
            srd_d = (sw_addr == chc_pkg::CMD_RDATA) ? res_q
                : {15'h0000, ready_q};
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            st_q <= CHC_PROBE;
            addr_q <= 8'h00;
            wdata_q <= 16'h0000;
            res_q <= 16'h0000;
            srd_q <= 16'h0000;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            wide_q <= 1'b0;
            ready_q <= 1'b0;
        end else begin
            st_q <= st_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            res_q <= res_d;
            srd_q <= srd_d;
            wr_q <= wr_d;
            rd_q <= rd_d;
            wide_q <= wide_d;
            ready_q <= ready_d;
        end
    end

    assign bus.addr = addr_q;
    assign bus.wdata = wdata_q;
    assign bus.wr = wr_q;
    assign bus.rd = rd_q;
    assign bus.wide = wide_q;
    assign sw_rdata = srd_q;
endmodule : chc_host
`default_nettype wire

/* File: chc_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
module chc_monitor (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [7:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic wide,
    input wire logic [15:0] rdata,
    input wire logic rvalid
);
    logic seen_q, seen_d, lp_q, lp_d, wide_q, wide_d, hic_w, obj_a;
    logic [7:0] hic_q, hic_d;
    logic [15:0] frb_q, frb_d;
    logic [7:0] mem_q [16];
    logic [7:0] mem_d [16];
    assign hic_w = wr && addr == chc_pkg::OFF_HIC;
    assign obj_a = addr[7:4] == 4'h1;
    // Shadows of host writes; a bus wake leaves lp_q stale, so the
    // checks that use it only hold again after the next interface write
    always_comb begin
        seen_d = seen_q | hic_w;
        hic_d = hic_w ? wdata[7:0] : hic_q;
        lp_d = hic_w ? (wdata[4] | wdata[3]) : lp_q;
        mem_d = mem_q;
        frb_d = frb_q;
        wide_d = wide_q;
        if (wr && obj_a && !lp_q) begin
            mem_d[addr[3:0]] = wdata[7:0];
        end
        if (rd && obj_a && !lp_q) begin
            frb_d = {mem_q[addr[3:0] + 4'h1], mem_q[addr[3:0]]};
            wide_d = wide;
        end
    end
    // Memory and buffer shadows keep their contents over reset
    always_ff @(posedge mclk) begin
        seen_q <= reset ? 1'b0 : seen_d;
        lp_q <= reset ? 1'b0 : lp_d;
        hic_q <= hic_d;
        mem_q <= mem_d;
        frb_q <= frb_d;
        wide_q <= wide_d;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    a_read_answer: assert property (rd |=> rvalid)
        else $error("read not answered next cycle");
    a_hic_reset_value: assert property (rd && addr == chc_pkg::OFF_HIC
        && !seen_q |=> rdata[7:0] == chc_pkg::HIC_RESET)
        else $error("interface register not at reset value");
    a_reset_flag_low: assert property (rd && addr == chc_pkg::OFF_HIC
        && !lp_q |=> !rdata[7])
        else $error("reset flag set after reset");
    a_reserved_zero: assert property (rd && addr == chc_pkg::OFF_HIC
        |=> !rdata[1])
        else $error("reserved bit reads one");
    a_mode_readback: assert property (rd && addr == chc_pkg::OFF_HIC
        && seen_q |=> {rdata[6:4], rdata[2], rdata[0]}
        == {hic_q[6:4], hic_q[2], hic_q[0]})
        else $error("interface register lost written bits");
    a_buffer_low: assert property (rd && addr == chc_pkg::OFF_FRB_LO
        && !lp_q |=> rdata[7:0] == frb_q[7:0])
        else $error("buffer low byte wrong");
    a_buffer_high: assert property (rd && addr == chc_pkg::OFF_FRB_LO
        && wide && wide_q && !lp_q |=> rdata[15:8] == frb_q[15:8])
        else $error("buffer high byte wrong");
    a_lec_unused: assert property (rd && addr == chc_pkg::OFF_STATUS
        |=> rdata[2:0] != 3'h7)
        else $error("error code seven produced");
    a_objects_refused: assert property (rd && obj_a && lp_q
        |=> rdata == 16'h0000)
        else $error("object read answered in low power");
endmodule : chc_monitor
`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
    localparam int WK = 8;
    logic mclk, reset, sw_wr, sw_rd, obj_irq, port_bit6, core_en, host_en;
    logic clock_out, osc_run, obj_blk, irq_main_n, irq_alt_n;
    logic [3:0] sw_addr, ev;
    logic [15:0] sw_wdata, sw_rdata, q;
    logic [1:0] power_mode;
    int errors, cmp_count, cc, hc, tg;
    chc_if bus_if ();
    chc_device #(.WAKE_CYCLES(WK)) chc_device_i (.mclk(mclk), .reset(reset),
        .bus(bus_if.dev), .crc_mismatch(ev[0]), .rx_done(ev[1]),
        .tx_done(ev[2]), .obj_irq(obj_irq), .bus_activity(ev[3]),
        .port_bit6_in(port_bit6), .core_clk_en(core_en),
        .host_clk_en(host_en), .clock_out(clock_out), .osc_run(osc_run),
        .objects_blocked(obj_blk), .irq_main_n(irq_main_n),
        .irq_alt_n(irq_alt_n), .power_mode(power_mode));
    chc_host chc_host_i (.mclk(mclk), .reset(reset), .bus(bus_if.host),
        .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
        .sw_rd(sw_rd), .sw_rdata(sw_rdata));
    chc_monitor chc_monitor_i (.mclk(mclk), .reset(reset),
        .addr(bus_if.addr), .wdata(bus_if.wdata), .wr(bus_if.wr),
        .rd(bus_if.rd), .wide(bus_if.wide), .rdata(bus_if.rdata),
        .rvalid(bus_if.rvalid));
    // 25 MHz system clock
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task automatic print_verdict;
        if (errors == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic sw_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge mclk);
        sw_wr <= 1'b0;
    endtask : sw_write
    // Read data stand only in the cycle after the strobe is taken
    task automatic sw_read(input logic [3:0] a, output logic [15:0] d);
        @(posedge mclk);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge mclk);
        sw_rd <= 1'b0;
        #1 d = sw_rdata;
    endtask : sw_read
    // Bounded poll of the host ready flag
    task automatic wait_ready;
        logic [15:0] d;
        for (int i = 0; i < 40; i++) begin
            sw_read(chc_pkg::CMD_STAT, d);
            if (d[0] === 1'b1) return;
        end
        errors++;
        $display("MISMATCH t=%0t host never ready", $time);
        print_verdict;
    endtask : wait_ready
    task automatic dev(input logic rw, input logic wd, input logic [7:0] a,
            input logic [15:0] d);
        sw_write(chc_pkg::CMD_ADDR, {7'h00, wd, a});
        sw_write(chc_pkg::CMD_WDATA, d);
        sw_write(chc_pkg::CMD_GO, {15'h0000, rw});
        wait_ready;
        sw_read(chc_pkg::CMD_RDATA, q);
    endtask : dev
    task automatic pulse(input int k);
        @(posedge mclk);
        ev[k] <= 1'b1;
        @(posedge mclk);
        ev[k] <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask : pulse
    // Enable rates and clock output for every divider setting
    task automatic t_clocks;
        logic pc;
        logic [15:0] ex;
        for (int k = 0; k < 5; k++) begin
            // Divider bits 6:5 walk all settings; pass 4 stops clock out
            dev(1'b0, 1'b0, chc_pkg::OFF_HIC, {9'h000, k[1:0], 5'h03});
            if (k == 4) dev(1'b0, 1'b0, chc_pkg::OFF_HIC, 16'h0000);
            dev(1'b1, 1'b0, chc_pkg::OFF_HIC, 16'h0000);
            ex = (k == 4) ? 16'h0000 : {9'h000, k[1:0], 5'h01};
            chk({8'h00, q[7:0]}, ex);
            {cc, hc, tg} = '0;
            @(negedge mclk);
            pc = clock_out;
            for (int c = 0; c < 24; c++) begin
                @(negedge mclk);
                cc += core_en;
                hc += host_en;
                tg += (clock_out !== pc) ? 1 : 0;
                pc = clock_out;
            end
            chk(16'(cc), 16'(24 / (1 + k[1])));
            chk(16'(hc), 16'(24 / ((1 + k[1]) * (1 + k[0]))));
            chk(16'(tg > 0), k == 4 ? 16'h0000 : 16'h0001);
        end
        dev(1'b0, 1'b0, chc_pkg::OFF_HIC, 16'h0061);
    endtask : t_clocks
    // Status interrupts, error code, object interrupt and pin remap
    task automatic t_irq;
        dev(1'b0, 1'b0, chc_pkg::OFF_CTRL, 16'h0006);
        for (int i = 0; i < 4; i++) begin
            pulse(1 + i / 2);
            chk({15'h0, irq_main_n}, 16'h0000);
            dev(1'b1, 1'b0, chc_pkg::OFF_IRQ_ID, 16'h0000);
            chk({8'h00, q[7:0]}, {8'h00, chc_pkg::IRQ_STATUS});
            dev(1'b1, 1'b0, chc_pkg::OFF_STATUS, 16'h0000);
            chk({15'h0, q[4 - i / 2]}, 16'h0001);
            dev(1'b1, 1'b0, chc_pkg::OFF_IRQ_ID, 16'h0000);
            chk({8'h00, q[7:0]}, {8'h00, chc_pkg::IRQ_NONE});
        end
        pulse(0);
        dev(1'b1, 1'b0, chc_pkg::OFF_STATUS, 16'h0000);
        chk({13'h0, q[2:0]}, {13'h0, chc_pkg::LEC_CRC});
        dev(1'b0, 1'b0, chc_pkg::OFF_CTRL, 16'h0002);
        obj_irq <= 1'b1;
        for (int b = 0; b < 2; b++) begin
            port_bit6 <= b[0];
            repeat (3) @(posedge mclk);
            chk({14'h0, irq_main_n, irq_alt_n}, {15'h0, b[0]});
        end
        dev(1'b0, 1'b0, chc_pkg::OFF_HIC, 16'h0065);
        chk({14'h0, irq_main_n, irq_alt_n}, 16'h0002);
        dev(1'b0, 1'b0, chc_pkg::OFF_HIC, 16'h0061);
        dev(1'b0, 1'b0, chc_pkg::OFF_CTRL, 16'h0000);
        chk({15'h0, irq_main_n}, 16'h0001);
        obj_irq <= 1'b0;
    endtask : t_irq
    // Double reads through the fast buffer, wide and narrow
    task automatic t_buffer;
        dev(1'b0, 1'b0, 8'h10, 16'h00A5);
        dev(1'b0, 1'b0, 8'h11, 16'h003C);
        dev(1'b1, 1'b1, 8'h10, 16'h0000);
        dev(1'b1, 1'b1, chc_pkg::OFF_FRB_LO, 16'h0000);
        chk(q, 16'h3CA5);
        dev(1'b1, 1'b0, 8'h11, 16'h0000);
        dev(1'b1, 1'b0, chc_pkg::OFF_FRB_LO, 16'h0000);
        chk({8'h00, q[7:0]}, 16'h003C);
    endtask : t_buffer
    // Sleep with bus wake, then power-down and its exit
    task automatic t_power;
        dev(1'b0, 1'b0, 8'h2F, 16'h0000);
        dev(1'b0, 1'b0, 8'h4F, 16'h0000);
        dev(1'b0, 1'b0, chc_pkg::OFF_HIC, 16'h0069);
        chk({12'h0, power_mode, osc_run, obj_blk}, 16'h0005);
        dev(1'b1, 1'b0, 8'h10, 16'h0000);
        chk(q, 16'h0000);
        dev(1'b1, 1'b0, chc_pkg::OFF_STATUS, 16'h0000);
        chk({15'h0, q[chc_pkg::ST_WAKE]}, 16'h0000);
        pulse(3);
        chk({14'h0, power_mode}, 16'h0001);
        for (tg = 0; tg < 30 && power_mode !== 2'b00; tg++) @(negedge mclk);
        chk(16'(tg < 30), 16'h0001);
        chk(16'(tg >= WK - 3), 16'h0001);
        dev(1'b1, 1'b0, chc_pkg::OFF_STATUS, 16'h0000);
        chk({15'h0, q[chc_pkg::ST_WAKE]}, 16'h0001);
        dev(1'b0, 1'b0, chc_pkg::OFF_HIC, 16'h0071);
        chk({14'h0, power_mode}, 16'h0002);
        dev(1'b0, 1'b0, chc_pkg::OFF_HIC, 16'h0061);
        dev(1'b1, 1'b0, chc_pkg::OFF_HIC, 16'h0000);
        chk({13'h0, power_mode, q[7]}, 16'h0000);
    endtask : t_power
    // Main sequence
    initial begin
        {reset, sw_wr, sw_rd, obj_irq, port_bit6} = 5'h10;
        {sw_addr, ev, sw_wdata} = '0;
        {errors, cmp_count} = '0;
        repeat (6) @(posedge mclk);
        reset <= 1'b0;
        wait_ready;
        dev(1'b1, 1'b0, chc_pkg::OFF_HIC, 16'h0000);
        chk({8'h00, q[7:0]}, {8'h00, chc_pkg::HIC_RESET});
        t_clocks;
        t_irq;
        t_buffer;
        t_power;
        print_verdict;
    end
endmodule : testbench
`default_nettype wire
